// ---- iotb_cfg.svh ----
//
// Contract
// RULE_01 - Tag write stores compare input at select
// RULE_02 - Word selects from decode or match lines
// RULE_03 - Low select source: match; high: decode
// RULE_04 - Registered write strobe writes both arrays
// RULE_05 - Registered tag read completes in two cycles
// RULE_06 - Tag reads only with direct select source
// RULE_07 - Override forces pointer and I/O flag match
// RULE_08 - Operation kind checked against entry privilege
// RULE_09 - Error high when privilege forbids access
// RULE_10 - Modified output shows matched entry bit
// RULE_11 - Permitted needs hit, no error, modified ok
// RULE_12 - Miss high when no entry matches
// RULE_13 - Reset forces direct data read state
// RULE_14 - Sixteen match lines tolerate multiple hits
// RULE_15 - Tag output gives matched or addressed tag
// RULE_16 - Sense amp off disables array outputs
// RULE_17 - Data write stores payload at select
// RULE_18 - Payload output shows selected data word
// RULE_19 - Direct address registered then decoded
// RULE_20 - Registered flush invalidates selected entry
// RULE_21 - Hold keeps both word selects unchanged
// RULE_22 - Set mask bit forces subfield match
// RULE_23 - Flush with masks 111 clears all valid
// RULE_24 - Registered hold freezes select next cycle
// RULE_25 - All inputs captured on rising clock edge
`ifndef IOTB_CFG_SVH
`define IOTB_CFG_SVH
`define IOTB_CTX_HI 41
`define IOTB_CTX_LO 34
`define IOTB_IX1_HI 33
`define IOTB_IX1_LO 26
`define IOTB_IX2_HI 25
`define IOTB_IX2_LO 20
`define IOTB_IX3_HI 19
`define IOTB_IX3_LO 14
`define IOTB_BIT_V 13
`define IOTB_BIT_P 12
`define IOTB_BIT_I 11
`define IOTB_BIT_S 10
`define IOTB_BIT_L1 9
`define IOTB_BIT_L2 8
`define IOTB_BIT_L3 7
`define IOTB_BIT_M 6
`define IOTB_PRIV_HI 5
`define IOTB_PRIV_LO 0
`define IOTB_ACC_WRITE_BIT 0
`define IOTB_LVL_ALL 3'h7
`define IOTB_READ_LATENCY 2
`endif

// ---- iotb_pkg.sv ----
package iotb_pkg;
  typedef logic [41:0] iotb_tag_type;
  typedef logic [27:0] iotb_data_type;
  typedef logic [15:0] iotb_sel_type;
  typedef enum logic [1:0]
  {
    IOTB_SRC_MATCH = 2'h1,
    IOTB_SRC_DIRECT = 2'h2
  } iotb_src_type;
endpackage

// ---- iotb_top.sv ----
`timescale 1ns/10ps
`include "iotb_cfg.svh"
module iotb_top
  import iotb_pkg::*;
#(
  parameter int ENTRIES = 16,
  parameter int TAG_W = 42,
  parameter int DATA_W = 28,
  parameter int ACC_W = 6
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEnable,
  input wire logic [TAG_W-1:0] tag_compare_in,
  input wire logic [DATA_W-1:0] entry_payload_in,
  input wire logic [ACC_W-1:0] operation_kind_in,
  input wire logic [3:0] directAddress,
  input wire logic select_source,
  input wire logic table_write_strobe,
  input wire logic tag_read_request,
  input wire logic flag_compare_override,
  input wire logic flushRequest,
  input wire logic holdSelect,
  input wire logic sense_amp_off,
  output logic [TAG_W-1:0] tag_value_out,
  output logic [DATA_W-1:0] entry_payload_out,
  output logic miss,
  output logic error,
  output logic modified_flag_out,
  output logic lookup_permitted,
  output logic tagReadValid
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // The arrays are never cleared; only valid bits change by flush.
  logic [TAG_W-1:0] tagArray [ENTRIES];
  logic [DATA_W-1:0] dataArray [ENTRIES];

  // ----------------------------------------------------------------
  // Registered inputs
  // ----------------------------------------------------------------
  logic [TAG_W-1:0] compareQ;
  logic [DATA_W-1:0] payloadQ;
  logic [ACC_W-1:0] accessQ;
  logic [3:0] addressQ;
  iotb_src_type sourceQ;
  logic writeQ;
  logic readQ;
  logic overrideQ;
  logic flushQ;
  logic holdQ;

  // ----------------------------------------------------------------
  // Second stage, aligned with the word select register
  // ----------------------------------------------------------------
  iotb_sel_type wordSelect;
  iotb_sel_type next_wordSelect;
  iotb_sel_type matchLines;
  logic [TAG_W-1:0] writeTag;
  logic [DATA_W-1:0] writeData;
  logic [ACC_W-1:0] accessD;
  logic writeD;
  logic flushD;
  logic readD;
  logic lookupD;

  function automatic iotb_sel_type decodeAddress(input logic [3:0] a);
    iotb_sel_type s;
    s = '0;
    s[a] = 1'b1;
    return s;
  endfunction

  // Several active selects OR together: defined levels, no damage.
  function automatic logic [TAG_W-1:0] pickTag(input iotb_sel_type s);
    logic [TAG_W-1:0] r;
    r = '0;
    for (int k = 0; k < ENTRIES; k++)
    begin
      if (s[k])
      begin
        r = r | tagArray[k];
      end
    end
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] pickData(input iotb_sel_type s);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int k = 0; k < ENTRIES; k++)
    begin
      if (s[k])
      begin
        r = r | dataArray[k];
      end
    end
    return r;
  endfunction

  function automatic logic entryMatch(
    input logic [TAG_W-1:0] t,
    input logic [TAG_W-1:0] c,
    input logic ovr
  );
    logic ctxOk;
    logic ix1Ok;
    logic ix2Ok;
    logic ix3Ok;
    logic flagOk;
    ctxOk = t[`IOTB_BIT_S] || c[`IOTB_BIT_S] ||
            (t[`IOTB_CTX_HI:`IOTB_CTX_LO] == c[`IOTB_CTX_HI:`IOTB_CTX_LO]); // RULE_22
    ix1Ok = t[`IOTB_BIT_L1] || c[`IOTB_BIT_L1] ||
            (t[`IOTB_IX1_HI:`IOTB_IX1_LO] == c[`IOTB_IX1_HI:`IOTB_IX1_LO]); // RULE_22
    ix2Ok = t[`IOTB_BIT_L2] || c[`IOTB_BIT_L2] ||
            (t[`IOTB_IX2_HI:`IOTB_IX2_LO] == c[`IOTB_IX2_HI:`IOTB_IX2_LO]); // RULE_22
    ix3Ok = t[`IOTB_BIT_L3] || c[`IOTB_BIT_L3] ||
            (t[`IOTB_IX3_HI:`IOTB_IX3_LO] == c[`IOTB_IX3_HI:`IOTB_IX3_LO]); // RULE_22
    flagOk = ovr || ((t[`IOTB_BIT_P] == c[`IOTB_BIT_P]) &&
                     (t[`IOTB_BIT_I] == c[`IOTB_BIT_I])); // RULE_07
    return (t[`IOTB_BIT_V] == c[`IOTB_BIT_V]) && ctxOk && ix1Ok && ix2Ok && ix3Ok && flagOk;
  endfunction

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  // Reset parks the block in a direct read with all actions idle, so
  // stale match lines can never produce a multiple hit.
  always_ff @(posedge clk_sys) // RULE_25
  begin
    if (reset)
    begin
      sourceQ <= IOTB_SRC_DIRECT; // RULE_13
      addressQ <= 4'h0;
      holdQ <= 1'b0;
    end
    else if (clkEnable)
    begin
      sourceQ <= select_source ? IOTB_SRC_DIRECT : IOTB_SRC_MATCH;
      addressQ <= directAddress; // RULE_19
      holdQ <= holdSelect; // RULE_24
    end
  end

  always_ff @(posedge clk_sys) // RULE_25
  begin
    if (reset)
    begin
      writeQ <= 1'b0;
      readQ <= 1'b0;
      overrideQ <= 1'b0;
      flushQ <= 1'b0;
    end
    else if (clkEnable)
    begin
      writeQ <= table_write_strobe; // RULE_04
      readQ <= tag_read_request; // RULE_05
      overrideQ <= flag_compare_override; // RULE_07
      flushQ <= flushRequest; // RULE_20
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      compareQ <= '0;
      payloadQ <= '0;
      accessQ <= '0;
    end
    else if (clkEnable)
    begin
      compareQ <= tag_compare_in;
      payloadQ <= entry_payload_in;
      accessQ <= operation_kind_in;
    end
  end

  // ----------------------------------------------------------------
  // Match lines
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int k = 0; k < ENTRIES; k++)
    begin
      matchLines[k] = entryMatch(tagArray[k], compareQ, overrideQ); // RULE_14
    end
  end

  // ----------------------------------------------------------------
  // Word select
  // ----------------------------------------------------------------
  always_comb
  begin
    next_wordSelect = wordSelect;
    if (!holdQ) // RULE_21
    begin
      case (sourceQ)
        IOTB_SRC_MATCH: next_wordSelect = matchLines; // RULE_03
        IOTB_SRC_DIRECT: next_wordSelect = decodeAddress(addressQ); // RULE_19
        default: next_wordSelect = decodeAddress(addressQ);
      endcase
    end
  end

  // One register serves tag and data arrays alike.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wordSelect <= decodeAddress(4'h0); // RULE_13
    end
    else if (clkEnable)
    begin
      wordSelect <= next_wordSelect; // RULE_02
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      writeD <= 1'b0;
      flushD <= 1'b0;
      readD <= 1'b0;
      lookupD <= 1'b0;
    end
    else if (clkEnable)
    begin
      writeD <= writeQ; // RULE_04
      flushD <= flushQ; // RULE_20
      readD <= readQ && (sourceQ == IOTB_SRC_DIRECT); // RULE_06
      lookupD <= (sourceQ == IOTB_SRC_MATCH) && !writeQ && !flushQ;
    end
  end

  // Write and flush data travel beside the word select they belong to.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      writeTag <= '0;
      writeData <= '0;
      accessD <= '0;
    end
    else if (clkEnable)
    begin
      writeTag <= compareQ;
      writeData <= payloadQ;
      accessD <= accessQ;
    end
  end

  // ----------------------------------------------------------------
  // Array updates
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset && clkEnable)
    begin
      for (int k = 0; k < ENTRIES; k++)
      begin
        if (flushD)
        begin
          if ({writeTag[`IOTB_BIT_L1], writeTag[`IOTB_BIT_L2],
               writeTag[`IOTB_BIT_L3]} == `IOTB_LVL_ALL) // RULE_23
          begin
            tagArray[k][`IOTB_BIT_V] <= 1'b0;
          end
          else if (wordSelect[k])
          begin
            tagArray[k][`IOTB_BIT_V] <= 1'b0; // RULE_20
          end
        end
        else if (writeD && wordSelect[k])
        begin
          tagArray[k] <= writeTag; // RULE_01
        end
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset && clkEnable)
    begin
      for (int k = 0; k < ENTRIES; k++)
      begin
        if (writeD && !flushD && wordSelect[k])
        begin
          dataArray[k] <= writeData; // RULE_17
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Lookup status
  // ----------------------------------------------------------------
  logic [TAG_W-1:0] selTag;
  logic selHit;
  logic privFault;
  logic modOk;

  always_comb
  begin
    selTag = pickTag(wordSelect); // RULE_15
    selHit = |wordSelect;
    privFault = selHit &&
      (|(accessD & ~selTag[`IOTB_PRIV_HI:`IOTB_PRIV_LO])); // RULE_08
    modOk = !accessD[`IOTB_ACC_WRITE_BIT] || selTag[`IOTB_BIT_M];
  end

  // Sense amplifiers off: outputs keep their last value, except tagReadValid, which drops low.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      miss <= 1'b1;
      error <= 1'b0;
      modified_flag_out <= 1'b0;
      lookup_permitted <= 1'b0;
    end
    else if (clkEnable && !sense_amp_off) // RULE_16
    begin
      if (lookupD)
      begin
        miss <= !selHit; // RULE_12
        error <= privFault; // RULE_09
        modified_flag_out <= selHit && selTag[`IOTB_BIT_M]; // RULE_10
        lookup_permitted <= selHit && !privFault && modOk; // RULE_11
      end
    end
  end

  // ----------------------------------------------------------------
  // Read outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tagReadValid <= 1'b0;
    end
    else if (clkEnable)
    begin
      tagReadValid <= readD && !sense_amp_off; // RULE_05
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tag_value_out <= '0;
    end
    else if (clkEnable && !sense_amp_off && (readD || lookupD)) // RULE_16
    begin
      tag_value_out <= selTag; // RULE_15
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      entry_payload_out <= '0;
    end
    else if (clkEnable && !sense_amp_off) // RULE_16
    begin
      entry_payload_out <= pickData(wordSelect); // RULE_18
    end
  end

endmodule

// ---- iotb_monitor.sv ----
`timescale 1ns/10ps
module iotb_monitor
(
  input logic clk_sys,
  input logic reset,
  input logic select_source,
  input logic table_write_strobe,
  input logic tag_read_request,
  input logic flushRequest,
  input logic sense_amp_off,
  input logic [5:0] operation_kind_in,
  input logic [41:0] tag_value_out,
  input logic miss,
  input logic error,
  input logic modified_flag_out,
  input logic lookup_permitted,
  input logic tagReadValid
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // Results register two edges after a request's capture edge; the checks see them at the third.
  sequence lookup_s;
    !select_source && !table_write_strobe && !flushRequest && !sense_amp_off;
  endsequence
  sequence read_s;
    tag_read_request && select_source && !sense_amp_off ##1 !sense_amp_off[*2];
  endsequence
  a_read_pulse: assert property (read_s |=> tagReadValid)
    else $error("tag read gave no pulse");
  a_read_cause: assert property (tagReadValid |-> $past(tag_read_request && select_source, 3))
    else $error("pulse without direct read");
  a_error_hit: assert property (error |-> !miss)
    else $error("error on a miss");
  a_permit_clean: assert property (lookup_permitted |-> !miss && !error)
    else $error("permit with miss or error");
  a_reset_idle: assert property ($fell(reset) |-> miss && !error && !lookup_permitted && !tagReadValid)
    else $error("outputs not idle after reset");
  a_sleep_hold: assert property (sense_amp_off[*3] |-> $stable(tag_value_out) && $stable(miss))
    else $error("outputs moved in powerdown");
  a_write_needs_m: assert property (lookup_s ##0 operation_kind_in[0] ##3 lookup_permitted |-> modified_flag_out)
    else $error("write permitted while unmodified");
  a_kind_clean: assert property (lookup_s ##0 operation_kind_in == 6'h00 |-> ##3 !error)
    else $error("fault on empty access kind");
endmodule
bind iotb_top iotb_monitor i_mon (.*);

// ---- iotb_ctl_model.sv ----
`timescale 1ns/10ps
module iotb_ctl_model
(
  input logic clk_sys,
  output logic [41:0] tagCmp,
  output logic [27:0] payload,
  output logic [5:0] kind,
  output logic [3:0] addr,
  output logic src,
  output logic wr,
  output logic rd,
  output logic fl,
  output logic ovr,
  output logic hold,
  output logic sleep
);
  // Lookups need a written table, so the select starts on the direct source.
  initial
  begin
    {tagCmp, payload, kind, addr, wr, rd, fl, ovr, hold, sleep} = '0;
    src = 1'b1;
  end
  // The op bits are sleep, hold, override, flush, read and write.
  task automatic issue(input logic s, input logic [5:0] op, input logic [3:0] a, input logic [41:0] t,
    input logic [27:0] d, input logic [5:0] k);
    @(posedge clk_sys);
    src <= s;
    wr <= op[0];
    rd <= op[1] && s;
    fl <= op[2];
    ovr <= op[3];
    hold <= op[4];
    sleep <= op[5];
    addr <= a;
    tagCmp <= t;
    payload <= d;
    kind <= k;
  endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/10ps
module tb
  import iotb_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic clkOn = 1'b1;
  iotb_tag_type tagCmp, tagOut, t;
  iotb_tag_type tags [16];
  iotb_data_type payIn, payOut;
  iotb_data_type pays [16];
  logic [5:0] kind, k;
  logic [3:0] addr;
  logic src, wr, rd, fl, ovr, hold, sleep, miss, error, modOut, permit, readValid, e;
  int badCount = 0;
  int checks = 0;
  int n;

  always #25 clk_sys = ~clk_sys;

  iotb_ctl_model i_ctl (.clk_sys(clk_sys), .tagCmp(tagCmp), .payload(payIn), .kind(kind), .addr(addr), .src(src),
    .wr(wr), .rd(rd), .fl(fl), .ovr(ovr), .hold(hold), .sleep(sleep));
  iotb_top i_dut (.clk_sys(clk_sys), .reset(reset), .clkEnable(clkOn), .tag_compare_in(tagCmp),
    .entry_payload_in(payIn), .operation_kind_in(kind), .directAddress(addr), .select_source(src),
    .table_write_strobe(wr), .tag_read_request(rd), .flag_compare_override(ovr), .flushRequest(fl),
    .holdSelect(hold), .sense_amp_off(sleep), .tag_value_out(tagOut), .entry_payload_out(payOut), .miss(miss),
    .error(error), .modified_flag_out(modOut), .lookup_permitted(permit), .tagReadValid(readValid));

  function automatic logic fault(input logic [5:0] kd, input iotb_tag_type x);
    return |(kd & ~x[5:0]);
  endfunction

  task automatic chk(input string what, input logic [41:0] seen, input logic [41:0] exp);
    checks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d badCount %0d", checks, badCount);
    if (badCount == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One request, one cycle with the same inputs but no op bits, then sample where its results land.
  task automatic go(input logic s, input logic [5:0] op, input logic [3:0] a, input iotb_tag_type tg,
    input iotb_data_type d, input logic [5:0] kd);
    i_ctl.issue(s, op, a, tg, d, kd);
    i_ctl.issue(s, 6'h00, a, tg, d, kd);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    badCount++;
    stop_test();
  end

  initial
  begin
    void'($urandom(32'hd230a66e));
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("reset miss", miss, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      tags[i] = 42'({$urandom, $urandom});
      tags[i][29:26] = i[3:0];
      tags[i][13:7] = {6'h20, i[0]};
      pays[i] = 28'($urandom);
      go(1'b1, 6'h01, i[3:0], tags[i], pays[i], 6'h00);
    end
    for (int i = 0; i < 16; i++)
    begin
      go(1'b1, 6'h02, i[3:0], 42'h0, 28'h0, 6'h00);
      chk("read tag", tagOut, tags[i]);
      chk("read valid", readValid, 1'b1);
      chk("read data", payOut, pays[i]);
    end
    for (int j = 0; j < 40; j++)
    begin
      n = $urandom % 16;
      k = (j == 0) ? 6'h00 : (j == 1) ? 6'h3f : 6'($urandom);
      t = tags[n];
      if (t[7])
        t[19:14] = 6'($urandom);
      t[7] = 1'b0;
      e = fault(k, tags[n]);
      go(1'b0, 6'h00, 4'h0, t, 28'h0, k);
      chk("hit", miss, 1'b0);
      chk("error", error, e);
      chk("modified", modOut, tags[n][6]);
      chk("permit", permit, !e && (!k[0] || tags[n][6]));
      chk("hit data", payOut, pays[n]);
      chk("hit tag", tagOut, tags[n]);
    end
    i_ctl.issue(1'b1, 6'h00, 4'h3, 42'h0, 28'h0, 6'h00);
    i_ctl.issue(1'b1, 6'h10, 4'h9, 42'h0, 28'h0, 6'h00);
    i_ctl.issue(1'b1, 6'h00, 4'h9, 42'h0, 28'h0, 6'h00);
    for (int j = 0; j < 3; j++)
    begin
      @(posedge clk_sys);
      #1;
      chk("held data", payOut, pays[j < 2 ? 3 : 9]);
    end
    i_ctl.issue(1'b1, 6'h00, 4'h1, 42'h0, 28'h0, 6'h00);
    clkOn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    clkOn <= 1'b1;
    #1;
    chk("frozen data", payOut, pays[9]);
    go(1'b0, 6'h00, 4'h0, tags[0] ^ (42'h1 << 34), 28'h0, 6'h00);
    chk("no hit", miss, 1'b1);
    t = tags[2] | 42'h1000;
    go(1'b0, 6'h00, 4'h0, t, 28'h0, 6'h00);
    chk("flag miss", miss, 1'b1);
    go(1'b0, 6'h08, 4'h0, t, 28'h0, 6'h00);
    chk("override hit", miss, 1'b0);
    go(1'b1, 6'h02, 4'h2, 42'h0, 28'h0, 6'h00);
    chk("direct tag", tagOut, tags[2]);
    repeat (4) i_ctl.issue(1'b1, 6'h22, 4'h4, 42'h0, 28'h0, 6'h00);
    #1;
    chk("sleep pulse", readValid, 1'b0);
    chk("sleep tag", tagOut, tags[2]);
    go(1'b0, 6'h04, 4'h0, tags[4], 28'h0, 6'h00);
    go(1'b0, 6'h00, 4'h0, tags[4], 28'h0, 6'h00);
    chk("flushed", miss, 1'b1);
    go(1'b0, 6'h00, 4'h0, tags[6], 28'h0, 6'h00);
    chk("kept", miss, 1'b0);
    go(1'b1, 6'h04, 4'h0, 42'h380, 28'h0, 6'h00);
    go(1'b0, 6'h00, 4'h0, tags[6], 28'h0, 6'h00);
    chk("all flushed", miss, 1'b1);
    stop_test();
  end
endmodule
